// ===== hdl/chb_objects.sv
// chb_objects: heartbeat, identity, sync overflow, verify and error objects
// assumes a register port master and a frame layer giving event pulses
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
// What this block does
// - zero heartbeat time or node id disables consumer monitoring entirely
// - consumer entry bits 0..15 are the expected heartbeat time in ms
// - consumer entry bits 16..23 are the monitored node id, rest zero
// - send own heartbeat every producer-time ms; zero sends nothing
// - heartbeat active suppresses node guarding timer and its emergency
// - read-only identity words; highest subindex reads four
// - sync counter restarts on reaching the overflow value
// - configuration date holds days since 1 January 1984
// - configuration time holds ms since midnight
// - comm error: 00 preop if operational, 01 keep, 02 stopped
// - internal error: 00 preop if operational, 02 stopped
module chb_objects
#(
    parameter logic [31:0] VENDOR_CODE  = 32'h0000_0001, // arbitrary value
    parameter logic [31:0] PRODUCT_CODE = 32'h0000_0002, // arbitrary value
    parameter logic [31:0] REVISION     = 32'h0000_0003, // arbitrary value
    parameter logic [31:0] SERIAL       = 32'h0000_0000
)
(
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire chb_pkg::chb_bus_t bus_i,
    output logic [31:0]           rdata_o,
    input  wire logic [7:0]       hb_rx_node_i,
    input  wire logic             hb_rx_i,
    input  wire logic             sync_rx_i,
    input  wire logic             guard_en_i,
    input  wire logic             int_err_i,
    input  wire logic             nmt_start_i,
    input  wire logic             nmt_preop_i,
    input  wire logic             nmt_stop_i,
    output logic                  hb_tx_o,
    output logic [7:0]            sync_cnt_o,
    output logic                  guard_run_o,
    output logic                  guard_emcy_en_o,
    output logic                  comm_err_o,
    output chb_pkg::chb_nmt_t     nmt_state_o
);
    import chb_pkg::*;

    typedef struct packed {
        logic [31:0] rdata;
        logic [31:0] cons_hb;
        logic [15:0] prod_hb;
        logic [7:0]  sync_ovf;
        logic [31:0] cfg_date;
        logic [31:0] cfg_time;
        logic [7:0]  err_comm;
        logic [7:0]  err_int;
        logic [15:0] prod_cnt;
        logic [15:0] cons_cnt;
        logic        cons_armed;
        logic        hb_tx;
        logic [7:0]  sync_cnt;
        logic        guard_run;
        logic        comm_err;
        logic        timed_out;
        chb_nmt_t    nmt;
    } chb_state_t;

    chb_state_t s_reg;
    chb_state_t s_next;
    logic       ms_tick;
    logic [15:0] cons_time;
    logic [7:0]  cons_node;
    logic        cons_en;
    logic        hb_en;
    logic        hb_seen;
    logic        timeout;

    chb_ms_tick u_tick
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .tick_o (ms_tick)
    );

    assign cons_time = s_reg.cons_hb[HB_TIME_LSB +: 16];
    assign cons_node = s_reg.cons_hb[HB_NODE_LSB +: 8];
    assign cons_en   = (cons_time != 16'h0000)
                     && (cons_node != 8'h00);
    assign hb_en     = (s_reg.prod_hb != 16'h0000);
    assign hb_seen   = cons_en && hb_rx_i
                     && (hb_rx_node_i == cons_node);
    assign timeout   = cons_en && s_reg.cons_armed && ms_tick
                     && (s_reg.cons_cnt + 16'h0001 >= cons_time);

    always_comb
    begin
        s_next = s_reg;
        s_next.hb_tx = 1'b0;
        s_next.comm_err = 1'b0;

        // register writes
        if (bus_i.wr)
        begin
            case (bus_i.addr)
                OFS_CONS_HB:
                    s_next.cons_hb = {8'h00, bus_i.wdata[23:0]};
                OFS_PROD_HB:  s_next.prod_hb = bus_i.wdata[15:0];
                // out-of-range values are the master's fault, stored as is
                OFS_SYNC_OVF: s_next.sync_ovf = bus_i.wdata[7:0];
                OFS_CFG_DATE: s_next.cfg_date = bus_i.wdata;
                OFS_CFG_TIME: s_next.cfg_time = bus_i.wdata;
                OFS_ERR_COMM: s_next.err_comm = bus_i.wdata[7:0];
                OFS_ERR_INT:  s_next.err_int = bus_i.wdata[7:0];
                default:      s_next.err_int = s_next.err_int;
            endcase
        end

        // register reads, data stands one cycle later only
        s_next.rdata = 32'h0000_0000;
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                OFS_CONS_HB:   s_next.rdata = s_reg.cons_hb;
                OFS_PROD_HB:   s_next.rdata = {16'h0000, s_reg.prod_hb};
                OFS_SYNC_OVF:  s_next.rdata = {24'h00_0000, s_reg.sync_ovf};
                OFS_ID_MAX:    s_next.rdata = {24'h00_0000, ID_SUB_MAX};
                OFS_ID_VENDOR: s_next.rdata = VENDOR_CODE;
                OFS_ID_PROD:   s_next.rdata = PRODUCT_CODE;
                OFS_ID_REV:    s_next.rdata = REVISION;
                OFS_ID_SERIAL: s_next.rdata = SERIAL;
                OFS_CFG_DATE:  s_next.rdata = s_reg.cfg_date;
                OFS_CFG_TIME:  s_next.rdata = s_reg.cfg_time;
                OFS_ERR_COMM:  s_next.rdata = {24'h00_0000, s_reg.err_comm};
                OFS_ERR_INT:   s_next.rdata = {24'h00_0000, s_reg.err_int};
                OFS_STATUS:    s_next.rdata = {20'h0_0000, s_reg.sync_cnt,
                                   s_reg.timed_out, s_reg.nmt[1:0],
                                   s_reg.guard_run};
                default:       s_next.rdata = 32'h0000_0000;
            endcase
        end

        // producer heartbeat, counter cleared while the period is zero and on each send
        if (!hb_en)
            s_next.prod_cnt = 16'h0000;
        else if (ms_tick)
        begin
            if (s_reg.prod_cnt + 16'h0001 >= s_reg.prod_hb)
            begin
                s_next.prod_cnt = 16'h0000;
                s_next.hb_tx = 1'b1;
            end
            else
                s_next.prod_cnt = s_reg.prod_cnt + 16'h0001;
        end

        // consumer monitor, armed by the first heartbeat seen
        if (!cons_en)
        begin
            s_next.cons_cnt = 16'h0000;
            s_next.cons_armed = 1'b0;
        end
        else if (hb_seen)
        begin
            s_next.cons_cnt = 16'h0000;
            s_next.cons_armed = 1'b1;
            s_next.timed_out = 1'b0;
        end
        else if (timeout)
        begin
            // one error per silence; rearmed by the next heartbeat
            s_next.cons_cnt = 16'h0000;
            s_next.cons_armed = 1'b0;
            s_next.timed_out = 1'b1;
            s_next.comm_err = 1'b1;
        end
        else if (ms_tick && s_reg.cons_armed)
            s_next.cons_cnt = s_reg.cons_cnt + 16'h0001;

        // node guarding gated off while heartbeat runs
        s_next.guard_run = guard_en_i && !hb_en;

        // sync counter
        if (sync_rx_i)
        begin
            if (s_reg.sync_ovf == 8'h00)
                s_next.sync_cnt = 8'h00;
            else if (s_reg.sync_cnt >= s_reg.sync_ovf)
                s_next.sync_cnt = 8'h01;
            else
                s_next.sync_cnt = s_reg.sync_cnt + 8'h01;
        end

        // nmt state: commands first, error reactions override
        if (nmt_start_i)
            s_next.nmt = CHB_OPER;
        else if (nmt_preop_i)
            s_next.nmt = CHB_PREOP;
        else if (nmt_stop_i)
            s_next.nmt = CHB_STOPPED;
        if (timeout)
        begin
            case (s_reg.err_comm)
                REACT_PREOP:
                    if (s_reg.nmt == CHB_OPER)
                        s_next.nmt = CHB_PREOP;
                REACT_STOP: s_next.nmt = CHB_STOPPED;
                default:    s_next.nmt = s_next.nmt;
            endcase
        end
        if (int_err_i)
        begin
            case (s_reg.err_int)
                REACT_PREOP:
                    if (s_reg.nmt == CHB_OPER && s_next.nmt != CHB_STOPPED)
                        s_next.nmt = CHB_PREOP;
                REACT_STOP: s_next.nmt = CHB_STOPPED;
                REACT_KEEP: s_next.nmt = s_next.nmt;
                default:    s_next.nmt = s_next.nmt;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
        if (rst_i)
        begin
            s_reg <= '0;
            s_reg.err_comm <= RST_ERR_COMM;
            s_reg.err_int <= RST_ERR_INT;
            s_reg.nmt <= CHB_PREOP;
        end
        else
            s_reg <= s_next;

    assign rdata_o         = s_reg.rdata;
    assign hb_tx_o         = s_reg.hb_tx;
    assign sync_cnt_o      = s_reg.sync_cnt;
    assign guard_run_o     = s_reg.guard_run;
    assign guard_emcy_en_o = s_reg.guard_run;
    assign comm_err_o      = s_reg.comm_err;
    assign nmt_state_o     = s_reg.nmt;

    prod_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s_reg.prod_hb == 16'h0000) |=> !hb_tx_o)
        else $error("heartbeat sent with zero period");
    cons_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !cons_en |=> !comm_err_o)
        else $error("timeout while monitoring disabled");
    guard_hb_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        hb_en |=> !guard_run_o && !guard_emcy_en_o)
        else $error("guarding active under heartbeat");
    sync_wrap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (sync_rx_i && s_reg.sync_ovf != 8'h00
         && s_reg.sync_cnt >= s_reg.sync_ovf) |=> sync_cnt_o == 8'h01)
        else $error("sync counter failed to restart");
    comm_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (timeout && s_reg.err_comm == REACT_STOP && !int_err_i)
        |=> nmt_state_o == CHB_STOPPED)
        else $error("comm error did not stop");
    int_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (int_err_i && s_reg.err_int == REACT_STOP)
        |=> nmt_state_o == CHB_STOPPED)
        else $error("internal error did not stop");
    int_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (int_err_i && s_reg.err_int == REACT_KEEP && !timeout && !nmt_start_i
         && !nmt_preop_i && !nmt_stop_i) |=> $stable(nmt_state_o))
        else $error("keep reaction changed state");
    hb_timeout_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        timeout |=> comm_err_o)
        else $error("timeout without comm error");
    id_max_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (bus_i.rd && bus_i.addr == OFS_ID_MAX) |=> rdata_o == 32'h0000_0004)
        else $error("identity subindex count wrong");
    cons_hi_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_reg.cons_hb[31:24] == 8'h00)
        else $error("reserved consumer bits set");
endmodule // chb_objects

// ===== hdl/chb_pkg.sv
// chb_pkg: constants and types for the heartbeat and nmt object block
// assumes a 10 MHz clock and a plain register port
package chb_pkg;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          MS_UNIT_NS    = 1_000_000;
    localparam int          CLK_NS        = 1_000_000_000 / CLK_HZ;
    localparam int          MS_CYCLES     = MS_UNIT_NS / CLK_NS;
    localparam logic [15:0] OFS_CONS_HB   = 16'h1016;
    localparam logic [15:0] OFS_PROD_HB   = 16'h1017;
    localparam logic [15:0] OFS_SYNC_OVF  = 16'h1019;
    localparam logic [15:0] OFS_ID_MAX    = 16'h1180;
    localparam logic [15:0] OFS_ID_VENDOR = 16'h1181;
    localparam logic [15:0] OFS_ID_PROD   = 16'h1182;
    localparam logic [15:0] OFS_ID_REV    = 16'h1183;
    localparam logic [15:0] OFS_ID_SERIAL = 16'h1184;
    localparam logic [15:0] OFS_CFG_DATE  = 16'h1201;
    localparam logic [15:0] OFS_CFG_TIME  = 16'h1202;
    localparam logic [15:0] OFS_ERR_COMM  = 16'h1291;
    localparam logic [15:0] OFS_ERR_INT   = 16'h1292;
    localparam logic [15:0] OFS_STATUS    = 16'h1300;
    localparam logic [7:0]  ID_SUB_MAX    = 8'h04;
    localparam int          HB_TIME_LSB   = 0;
    localparam int          HB_NODE_LSB   = 16;
    localparam logic [7:0]  RST_ERR_COMM  = 8'h00;
    localparam logic [7:0]  RST_ERR_INT   = 8'h01;
    localparam logic [7:0]  REACT_PREOP   = 8'h00;
    localparam logic [7:0]  REACT_KEEP    = 8'h01;
    localparam logic [7:0]  REACT_STOP    = 8'h02;

    typedef enum logic [1:0] {
        CHB_PREOP,
        CHB_OPER,
        CHB_STOPPED
    } chb_nmt_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } chb_bus_t;
endpackage

// ===== hdl/chb_ms_tick.sv
// chb_ms_tick: one-cycle enable once per millisecond
// assumes the package clock rate
`timescale 1ns/10ps
module chb_ms_tick
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    import chb_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } chb_tick_st_t;

    chb_tick_st_t s_reg;
    chb_tick_st_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == 16'(MS_CYCLES - 1))
        begin
            s_next.cnt = 16'h0000;
            s_next.tick = 1'b1;
        end
        else
            s_next.cnt = s_reg.cnt + 16'h0001;
    end

    always_ff @(posedge mclk_i)
        if (rst_i)
            s_reg <= '0;
        else
            s_reg <= s_next;

    assign tick_o = s_reg.tick;
endmodule // chb_ms_tick

// ===== bench/chb_hb_peer.sv
// chb_hb_peer: network master side, sends heartbeats and times ours
// assumes one clock shared with the node and one-cycle event pulses
`timescale 1ns/10ps
module chb_hb_peer
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        send_i,
    input  wire logic [7:0]  node_i,
    input  wire logic        hb_tx_i,
    output logic             hb_rx_o,
    output logic [7:0]       hb_rx_node_o,
    output logic [31:0]      tx_count_o,
    output logic [31:0]      tx_gap_o
);
    logic [31:0] since_reg;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            hb_rx_o      <= 1'b0;
            hb_rx_node_o <= 8'h00;
            tx_count_o   <= 32'h0;
            tx_gap_o     <= 32'h0;
            since_reg    <= 32'h0;
        end
        else
        begin
            hb_rx_o      <= send_i;
            // idle id churns so a stale id is never trusted
            hb_rx_node_o <= send_i ? node_i : ~hb_rx_node_o;
            since_reg    <= hb_tx_i ? 32'h1 : since_reg + 1;
            if (hb_tx_i)
            begin
                tx_count_o <= tx_count_o + 1;
                tx_gap_o   <= since_reg;
            end
        end
    end
endmodule // chb_hb_peer

// ===== bench/tb_top.sv
// tb_top: self-checking bench for the heartbeat and nmt object block
// assumes chb_pkg, chb_objects and chb_hb_peer are compiled first
`timescale 1ns/10ps
module tb_top;
    import chb_pkg::*;
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } chb_row_t;
    localparam logic [31:0] VEND = 32'h0000_00A1; // arbitrary value
    localparam logic [31:0] PRDC = 32'h0000_00B2; // arbitrary value
    localparam logic [31:0] REVN = 32'h0000_00C3; // arbitrary value
    logic        mclk_i, rst_i, guard_en, send, hb_rx, hb_tx, comm_err;
    logic        guard_run, guard_emcy;
    logic [4:0]  ev;
    logic [7:0]  send_node, hb_node, sync_cnt;
    logic [31:0] rdata, tx_count, tx_gap, c0, t0;
    chb_bus_t    bus;
    chb_nmt_t    nmt;
    int          err_total, n_checks, comm_cnt, i;
    chb_nmt_t    nmt_exp[3] = '{CHB_PREOP, CHB_OPER, CHB_STOPPED};
    chb_row_t    rows[21] = '{
        '{0, OFS_CONS_HB, 0, 0}, '{0, OFS_PROD_HB, 0, 0},
        '{0, OFS_SYNC_OVF, 0, 0}, '{0, OFS_ID_MAX, 0, 4},
        '{0, OFS_ID_VENDOR, 0, VEND}, '{0, OFS_ID_PROD, 0, PRDC},
        '{0, OFS_ID_REV, 0, REVN}, '{0, OFS_ID_SERIAL, 0, 0},
        '{0, OFS_CFG_DATE, 0, 0}, '{0, OFS_CFG_TIME, 0, 0},
        '{0, OFS_ERR_COMM, 0, 0}, '{0, OFS_ERR_INT, 0, 1},
        '{1, OFS_CONS_HB, 32'hFF05_0003, 32'h0005_0003},
        '{1, OFS_PROD_HB, 32'h1234_0002, 32'h2},
        '{1, OFS_SYNC_OVF, 32'h3, 32'h3},
        '{1, OFS_CFG_DATE, 32'h3A2B, 32'h3A2B},
        '{1, OFS_CFG_TIME, 32'h0526_5BFF, 32'h0526_5BFF},
        '{1, OFS_ERR_COMM, 32'h2, 32'h2},
        '{1, OFS_ID_VENDOR, 32'hFFFF_FFFF, VEND},
        '{1, OFS_ID_MAX, 32'hFF, 32'h4},
        '{1, 16'h1500, 32'h1234, 32'h0}};

    chb_objects #(.VENDOR_CODE(VEND), .PRODUCT_CODE(PRDC),
        .REVISION(REVN), .SERIAL(32'h0)) dut (.mclk_i(mclk_i),
        .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .hb_rx_node_i(hb_node),
        .hb_rx_i(hb_rx), .sync_rx_i(ev[0]), .guard_en_i(guard_en),
        .int_err_i(ev[1]), .nmt_start_i(ev[2]), .nmt_preop_i(ev[3]),
        .nmt_stop_i(ev[4]), .hb_tx_o(hb_tx), .sync_cnt_o(sync_cnt),
        .guard_run_o(guard_run), .guard_emcy_en_o(guard_emcy),
        .comm_err_o(comm_err), .nmt_state_o(nmt));
    chb_hb_peer peer (.mclk_i(mclk_i), .rst_i(rst_i), .send_i(send),
        .node_i(send_node), .hb_tx_i(hb_tx), .hb_rx_o(hb_rx),
        .hb_rx_node_o(hb_node), .tx_count_o(tx_count), .tx_gap_o(tx_gap));

    always @(posedge mclk_i)
        if (comm_err === 1'b1)
            comm_cnt++;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_i);
        bus <= '0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk_i);
        bus <= '0;
        #1;
        chk($sformatf("reg %h", a), e, rdata);
    endtask

    // pulse, then one spare edge so the registered answer has landed
    task automatic evt(input logic [4:0] v);
        @(posedge mclk_i);
        ev <= v;
        @(posedge mclk_i);
        ev <= '0;
        @(posedge mclk_i);
        #1;
    endtask

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    initial
    begin
        repeat (9 * MS_CYCLES) @(posedge mclk_i);
        err_total++;
        print_verdict();
    end

    initial
    begin
        rst_i = 1'b1;
        bus = '0;
        ev = '0;
        guard_en = 1'b1;
        send = 1'b0;
        send_node = 8'h00;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk("nmt", CHB_PREOP, nmt);
        chk("guard_run", 1, guard_run);
        evt(5'b00001);
        chk("sync_cnt", 0, sync_cnt);
        foreach (rows[k])
        begin
            if (rows[k].wr)
                wr_reg(rows[k].addr, rows[k].wdata);
            rd_chk(rows[k].addr, rows[k].exp);
        end
        @(posedge mclk_i);
        #1;
        chk("guard_run", 0, guard_run);
        chk("guard_emcy", 0, guard_emcy);
        for (int k = 1; k <= 4; k++)
        begin
            evt(5'b00001);
            chk("sync_cnt", (k == 4) ? 1 : k, sync_cnt);
        end
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(OFS_ERR_INT, 32'(k));
            evt(5'b00100);
            chk("nmt", CHB_OPER, nmt);
            evt(5'b00010);
            chk("nmt", nmt_exp[k], nmt);
        end
        wr_reg(OFS_ERR_INT, 32'h0);
        evt(5'b00100);
        evt(5'b01000);
        evt(5'b00010);
        chk("nmt", CHB_PREOP, nmt);
        evt(5'b00100);
        @(posedge mclk_i);
        send <= 1'b1;
        send_node <= 8'h05;
        @(posedge mclk_i);
        send <= 1'b0;
        // other node keeps talking; it must not refresh the watch
        for (i = 0; i < 3 * MS_CYCLES + 100 && comm_err !== 1'b1; i++)
        begin
            @(posedge mclk_i);
            send_node <= 8'h06;
            send <= (i % 5000 == 4999);
            #1;
        end
        chk("timeout", 1, i >= 2 * MS_CYCLES && i <= 3 * MS_CYCLES);
        @(posedge mclk_i);
        send <= 1'b0;
        #1;
        chk("nmt", CHB_STOPPED, nmt);
        for (i = 0; i < 4 * MS_CYCLES && tx_count < 2; i++)
            @(posedge mclk_i);
        chk("hb_gap", 2 * MS_CYCLES, tx_gap);
        wr_reg(OFS_CONS_HB, 32'h0005_0000);
        wr_reg(OFS_PROD_HB, 32'h0);
        c0 = comm_cnt;
        t0 = tx_count;
        @(posedge mclk_i);
        send <= 1'b1;
        send_node <= 8'h05;
        @(posedge mclk_i);
        send <= 1'b0;
        repeat (2 * MS_CYCLES + 100) @(posedge mclk_i);
        chk("comm_err_cnt", c0, comm_cnt);
        chk("hb_tx_cnt", t0, tx_count);
        print_verdict();
    end
endmodule // tb_top
